// *** verilog/vsfa_top.v ***
// Symbol encoder, decoder, framer and arbiter for a single-wire VPW link.
// Assumes an external transceiver: line_drive high drives the wire active,
// line_in shows the wired-OR level, asynchronous to sys_clk.
//
// Functional notes
// - Line is wired-OR, active high, rests passive.
// - One symbol per transition, timed between transitions.
// - Frame: SOF, header, data, check, EOD, responses, EOF.
// - At most twelve bytes per message.
// - Bytes travel most significant bit first.
// - Zero: long active/short passive; one: the reverse.
// - Transmit short 64 us, long 128 us.
// - Receive: <=34 illegal, <=96 short, <=163 long.
// - SOF active 200 us; arbitration starts there.
// - Send SOF only after inter-frame separation.
// - After check byte release line for EOD.
// - Nobody drives before EOD is detected.
// - No response: passive until EOF closes frame.
// - Normalization symbol precedes first response byte.
// - Long normalization with check byte, else short.
// - Message types zero to three supported.
// - Arbitrate every symbol; zero beats one.
// - Fourfold receive-only fast mode.
// - Frames start and end passive.
// - Compare each symbol sent; mismatch releases line.
// - Separation reached by nominal time or EOF plus rise.
// - Break returns to receive; rearbitrate after separation.
// - Type 2 loser retries each byte; winner stops.
`timescale 1ns/1ps
`default_nettype none
`include "vsfa_regs.vh"

module vsfa_top (
    input wire sys_clk,
    input wire srst,
    input wire line_in,
    output reg line_drive,
    input wire hs_mode,
    input wire [7:0] tx_data,
    input wire tx_last,
    input wire tx_is_ifr,
    input wire [1:0] ifr_type,
    input wire tx_valid,
    output wire tx_ready,
    output wire [7:0] rx_data,
    output wire rx_ifr,
    output wire rx_valid,
    input wire rx_ready,
    output reg rx_sof,
    output reg rx_eod,
    output reg rx_eof,
    output reg rx_brk,
    output reg rx_illegal,
    output reg rx_nb_crc,
    output reg rx_ovf,
    output reg len_err,
    output reg arb_lost,
    output reg tx_done,
    output reg bus_idle
);

    localparam R_IDLE = 2'd0;
    localparam R_DATA = 2'd1;
    localparam R_NB = 2'd2;
    localparam R_IFR = 2'd3;
    localparam T_IDLE = 3'd0;
    localparam T_WAIT = 3'd1;
    localparam T_SOF = 3'd2;
    localparam T_BITS = 3'd3;
    localparam T_RSP = 3'd4;
    localparam T_NB = 3'd5;
    localparam T_DRAIN = 3'd6;
    localparam T_HOLD = 3'd7;

    wire line_s;
    reg line_q;
    reg [8:0] dur;
    reg [6:0] acc;
    reg tick;
    reg [1:0] rphase;
    reg [7:0] rsh;
    reg [2:0] rbits;
    reg [3:0] rbytes;
    reg rx_push;
    reg [8:0] rx_word;
    reg [2:0] tstate;
    reg [7:0] cbyte;
    reg clast;
    reg [2:0] cbit;
    reg ifr;
    reg [1:0] itype;
    reg [3:0] tbytes;
    reg [8:0] tgt;
    wire [8:0] txb_data;
    wire txb_valid;
    wire rxb_ready;

    // =====================================================================
    // Pin input and buffers
    // =====================================================================
    vsfa_sync #(.WIDTH(1)) u_sync (
        .sys_clk(sys_clk),
        .srst(srst),
        .din(line_in),
        .dout(line_s)
    );

    wire tx_pop;
    vsfa_buf2 #(.WIDTH(9)) u_txbuf (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_data({tx_last, tx_data}),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(txb_data),
        .out_valid(txb_valid),
        .out_ready(tx_pop)
    );

    // A stalled reader fills this buffer; a byte arriving then is flagged.
    vsfa_buf2 #(.WIDTH(9)) u_rxbuf (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_data(rx_word),
        .in_valid(rx_push),
        .in_ready(rxb_ready),
        .out_data({rx_ifr, rx_data}),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // =====================================================================
    // Timebase and duration counter
    // =====================================================================
    // Fractional accumulator keeps the fast mode exact: 4 steps per 125.
    wire [6:0] step = hs_mode ? `VSFA_STEP_FAST : `VSFA_STEP_NORM;
    wire [7:0] acc_sum = {1'b0, acc} + {1'b0, step};
    wire [7:0] acc_wrap = acc_sum - {1'b0, `VSFA_TICK_CYC};
    wire edge_w = line_s ^ line_q;
    wire rise = edge_w & line_s;

    // Counter restarts at every transition and saturates instead of wrapping.
    always @(posedge sys_clk) begin
        if (srst) begin
            acc <= 7'h00;
            tick <= 1'b0;
            line_q <= 1'b0;
            dur <= 9'h000;
        end else begin
            if (acc_sum >= {1'b0, `VSFA_TICK_CYC}) begin
                acc <= acc_wrap[6:0];
                tick <= 1'b1;
            end else begin
                acc <= acc_sum[6:0];
                tick <= 1'b0;
            end
            line_q <= line_s;
            if (edge_w) begin
                dur <= 9'h000;
            end else if (tick && dur != 9'h1FF) begin
                dur <= dur + 9'h001;
            end
        end
    end

    // =====================================================================
    // Symbol classification of the interval just ended
    // =====================================================================
    wire c_ill = (dur <= `VSFA_ILL_MAX);
    wire c_short = !c_ill && (dur <= `VSFA_SHORT_MAX);
    wire c_long = (dur > `VSFA_SHORT_MAX) && (dur <= `VSFA_LONG_MAX);
    wire c_bitv = c_short | c_long;
    wire c_bit = line_q ? c_short : c_long;
    wire c_sof = line_q && (dur > `VSFA_LONG_MAX) && (dur <= `VSFA_SOF_MAX);
    wire c_brk = line_q && (dur > `VSFA_SOF_MAX);
    wire bit_take = edge_w && c_bitv && (rphase == R_DATA || rphase == R_IFR);
    wire passive_tick = tick && !line_s && !edge_w;
    wire eod_now = passive_tick && (dur == `VSFA_LONG_MAX) && (rphase == R_DATA);
    wire eof_now = passive_tick && (dur == `VSFA_EOF_MIN) &&
        (rphase == R_NB || rphase == R_IFR);
    wire brk_now = edge_w && !line_s && c_brk;

    // =====================================================================
    // Receive framing
    // =====================================================================
    wire tx_len_hit;
    always @(posedge sys_clk) begin
        if (srst) begin
            rphase <= R_IDLE;
            rsh <= 8'h00;
            rbits <= 3'h0;
            rbytes <= 4'h0;
            rx_push <= 1'b0;
            rx_word <= 9'h000;
            {rx_sof, rx_eod, rx_eof, rx_brk, rx_illegal} <= 5'h00;
            {rx_nb_crc, rx_ovf, len_err, bus_idle} <= 4'h0;
        end else begin
            {rx_sof, rx_eod, rx_eof, rx_brk, rx_illegal} <= 5'h00;
            rx_push <= 1'b0;
            rx_ovf <= rx_push && !rxb_ready;
            len_err <= tx_len_hit;
            bus_idle <= !line_s && (dur >= `VSFA_IFS_NOM);
            if (edge_w && c_ill) begin
                rx_illegal <= 1'b1;
            end else if (edge_w && c_sof) begin
                rphase <= R_DATA;
                rbits <= 3'h0;
                rbytes <= 4'h0;
                rx_sof <= 1'b1;
            end else if (brk_now) begin
                rphase <= R_IDLE;
                rx_brk <= 1'b1;
            end else if (edge_w && !line_s && rphase == R_NB) begin
                rphase <= R_IFR;
                rbits <= 3'h0;
                rx_nb_crc <= c_long;
            end else if (bit_take) begin
                rsh <= {rsh[6:0], c_bit};
                rbits <= rbits + 3'h1;
                if (rbits == 3'h7) begin
                    rx_push <= 1'b1;
                    rx_word <= {rphase == R_IFR, rsh[6:0], c_bit};
                    rbytes <= rbytes + 4'h1;
                    if (rbytes == `VSFA_MAX_BYTES) begin
                        len_err <= 1'b1;
                    end
                end
            end else if (eod_now) begin
                rphase <= R_NB;
                rx_eod <= 1'b1;
            end else if (eof_now) begin
                rphase <= R_IDLE;
                rx_eof <= 1'b1;
            end
        end
    end

    // =====================================================================
    // Transmit symbol timing
    // =====================================================================
    // Long width when the level and the bit differ: active zero, passive one.
    always @* begin
        tgt = `VSFA_T_SHORT;
        if (tstate == T_SOF) begin
            tgt = `VSFA_T_SOF;
        end else if (tstate == T_NB) begin
            if (itype == 2'd3) begin
                tgt = `VSFA_T_LONG;
            end
        end else if (line_drive ^ cbyte[cbit]) begin
            tgt = `VSFA_T_LONG;
        end
    end

    // Toggle only once the wire shows our own level, so the sync delay
    // cannot cause a second toggle before the edge arrives.
    wire timing = (tstate == T_SOF || tstate == T_NB || tstate == T_BITS);
    wire tgl = timing && tick && (line_s == line_drive) && (dur == tgt - 9'h001);
    wire match = c_bitv && (c_bit == cbyte[cbit]);
    wire byte_end = tstate == T_BITS && edge_w && match && cbit == 3'h0;
    assign tx_len_hit = byte_end && !clast && tbytes == `VSFA_MAX_BYTES - 4'h1;
    wire adv = byte_end && !clast && txb_valid && !tx_len_hit;
    wire start_ok = (!line_s && dur >= `VSFA_IFS_NOM) ||
        (rise && dur > `VSFA_EOF_MIN);
    assign tx_pop = (tstate == T_IDLE && txb_valid && !hs_mode) || adv ||
        (tstate == T_DRAIN && txb_valid);
    wire [2:0] lost_state = clast ? T_IDLE : T_DRAIN;

    // =====================================================================
    // Transmit framing and arbitration
    // =====================================================================
    always @(posedge sys_clk) begin
        if (srst) begin
            tstate <= T_IDLE;
            line_drive <= 1'b0;
            cbyte <= 8'h00;
            clast <= 1'b0;
            cbit <= 3'h7;
            ifr <= 1'b0;
            itype <= 2'd0;
            tbytes <= 4'h0;
            arb_lost <= 1'b0;
            tx_done <= 1'b0;
        end else begin
            arb_lost <= 1'b0;
            tx_done <= 1'b0;
            if (tgl) begin
                line_drive <= ~line_drive;
            end
            case (tstate)
                T_IDLE: begin
                    if (txb_valid && !hs_mode) begin
                        cbyte <= txb_data[7:0];
                        clast <= txb_data[8];
                        cbit <= 3'h7;
                        ifr <= tx_is_ifr;
                        itype <= ifr_type;
                        tbytes <= 4'h0;
                        tstate <= tx_is_ifr ? T_RSP : T_WAIT;
                    end
                end
                T_WAIT: begin
                    if (start_ok) begin
                        line_drive <= 1'b1;
                        tstate <= T_SOF;
                    end
                end
                T_SOF: begin
                    if (edge_w && !line_s) begin
                        if (c_sof) begin
                            tstate <= T_BITS;
                        end else begin
                            line_drive <= 1'b0;
                            arb_lost <= 1'b1;
                            tstate <= lost_state;
                        end
                    end
                end
                T_RSP: begin
                    if (eod_now) begin
                        line_drive <= 1'b1;
                        tbytes <= rbytes;
                        tstate <= T_NB;
                    end else if (brk_now || eof_now) begin
                        tstate <= lost_state;
                    end
                end
                T_NB: begin
                    if (edge_w && !line_s) begin
                        if ((itype == 2'd3) == c_long && c_bitv) begin
                            tstate <= T_BITS;
                        end else begin
                            line_drive <= 1'b0;
                            arb_lost <= 1'b1;
                            tstate <= lost_state;
                        end
                    end
                end
                T_BITS: begin
                    if (edge_w && !match) begin
                        line_drive <= 1'b0;
                        arb_lost <= 1'b1;
                        if (ifr && itype == 2'd2 && c_bitv) begin
                            cbit <= cbit - 3'h1;
                            tstate <= (cbit == 3'h0) ? T_BITS : T_HOLD;
                        end else begin
                            tstate <= lost_state;
                        end
                    end else if (edge_w) begin
                        line_drive <= line_s;
                        cbit <= cbit - 3'h1;
                        if (cbit == 3'h0) begin
                            tbytes <= tbytes + 4'h1;
                            if (clast) begin
                                line_drive <= 1'b0;
                                tx_done <= 1'b1;
                                tstate <= T_IDLE;
                            end else if (adv) begin
                                cbyte <= txb_data[7:0];
                                clast <= txb_data[8];
                            end else begin
                                line_drive <= 1'b0;
                                arb_lost <= 1'b1;
                                tstate <= T_DRAIN;
                            end
                        end
                    end
                end
                T_HOLD: begin
                    if (eof_now || brk_now) begin
                        tstate <= T_IDLE;
                    end else if (bit_take) begin
                        cbit <= cbit - 3'h1;
                        if (cbit == 3'h0) begin
                            line_drive <= line_s;
                            tstate <= T_BITS;
                        end
                    end
                end
                T_DRAIN: begin
                    if (txb_valid && txb_data[8]) begin
                        tstate <= T_IDLE;
                    end
                end
                default: begin
                    tstate <= T_IDLE;
                end
            endcase
        end
    end

endmodule // vsfa_top

`default_nettype wire

// *** verilog/vsfa_regs.vh ***
// Timing and framing constants of the single-wire pulse-width link block.
// Assumes a 125 MHz system clock; all symbol times are in microseconds.
`ifndef VSFA_REGS_VH
`define VSFA_REGS_VH

// System clock in MHz and the microsecond tick derived from it.
`define VSFA_CLK_MHZ 7'h7D
`define VSFA_TICK_CYC (`VSFA_CLK_MHZ)
// Tick accumulator steps for normal and fourfold receive rate.
`define VSFA_STEP_NORM 7'h01
`define VSFA_STEP_FAST 7'h04

// Receive classification limits in microseconds (inclusive maxima).
`define VSFA_ILL_MAX 9'h022
`define VSFA_SHORT_MAX 9'h060
`define VSFA_LONG_MAX 9'h0A3
`define VSFA_SOF_MAX 9'h0EF
// Passive interval that counts as end of frame once exceeded.
`define VSFA_EOF_MIN 9'h0EF
// Nominal inter-frame separation; once it is reached the line is idle.
`define VSFA_IFS_NOM 9'h12C

// Transmit nominal widths in microseconds.
`define VSFA_T_SHORT 9'h040
`define VSFA_T_LONG 9'h080
`define VSFA_T_SOF 9'h0C8

// Largest message in bytes, responses included.
`define VSFA_MAX_BYTES 4'hC

`endif

// *** verilog/vsfa_sync.v ***
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes the input changes slowly compared to the system clock.
`timescale 1ns/1ps
`default_nettype none

module vsfa_sync #(
    parameter WIDTH = 1
) (
    input wire sys_clk,
    input wire srst,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] stage1;

    // =====================================================================
    // Synchroniser stages
    // =====================================================================
    // The first stage feeds the second stage and nothing else.
    always @(posedge sys_clk) begin
        if (srst) begin
            stage1 <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end

endmodule // vsfa_sync

`default_nettype wire

// *** verilog/vsfa_buf2.v ***
// Two-entry buffer with valid and ready on both sides.
// Assumes both sides run on sys_clk; all outputs are registered.
`timescale 1ns/1ps
`default_nettype none

module vsfa_buf2 #(
    parameter WIDTH = 8
) (
    input wire sys_clk,
    input wire srst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output reg in_ready,
    output reg [WIDTH-1:0] out_data,
    output reg out_valid,
    input wire out_ready
);

    reg [WIDTH-1:0] spare;
    reg spare_valid;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // =====================================================================
    // Storage
    // =====================================================================
    // Head word sits in out_data, a second word waits in spare; ready is
    // registered so a full buffer stalls the filler without a comb path.
    always @(posedge sys_clk) begin
        if (srst) begin
            out_data <= {WIDTH{1'b0}};
            out_valid <= 1'b0;
            spare <= {WIDTH{1'b0}};
            spare_valid <= 1'b0;
            in_ready <= 1'b1;
        end else begin
            if (pop) begin
                if (spare_valid) begin
                    out_data <= spare;
                    if (push) begin
                        spare <= in_data;
                    end
                    spare_valid <= push;
                    in_ready <= ~push;
                end else begin
                    if (push) begin
                        out_data <= in_data;
                    end
                    out_valid <= push;
                    in_ready <= 1'b1;
                end
            end else if (push) begin
                if (!out_valid) begin
                    out_data <= in_data;
                    out_valid <= 1'b1;
                    in_ready <= 1'b1;
                end else begin
                    spare <= in_data;
                    spare_valid <= 1'b1;
                    in_ready <= 1'b0;
                end
            end
        end
    end

endmodule // vsfa_buf2

`default_nettype wire

// *** testbench/vsfa_top_asserts.sv ***
// Checker for the link block; it sees only the ports of the top module.
// Assumes line_in is the wired-OR of line_drive and the other nodes.
`timescale 1ns/1ps
`default_nettype none

module vsfa_top_asserts (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic line_in,
    input wire logic line_drive,
    input wire logic hs_mode,
    input wire logic tx_ready,
    input wire logic tx_is_ifr,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic rx_eod,
    input wire logic rx_eof,
    input wire logic rx_brk,
    input wire logic rx_illegal,
    input wire logic arb_lost
);
    // ====
    // Run lengths in cycles; one microsecond is 125 cycles.
    logic [16:0] hi_w = 17'h0;
    logic [16:0] lo_w = 17'h0;
    logic [16:0] run = 17'h0;
    logic [16:0] last_run = 17'h0;
    logic line_q = 1'b0;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);

    // The lo_w and run counters saturate, so a long idle line never wraps into a short run.
    // They restart with the block, so an unknown line before reset cannot poison them.
    always @(posedge sys_clk) begin
        if (srst) begin
            {hi_w, lo_w, run, last_run} <= '0;
            line_q <= 1'b0;
        end else begin
            line_q <= line_in;
            hi_w <= line_drive ? hi_w + 17'h1 : 17'h0;
            lo_w <= line_in ? 17'h0 : lo_w + {16'h0, ~&lo_w};
            run <= (line_in != line_q) ? 17'h1 : run + {16'h0, ~&run};
            if (line_in != line_q) begin
                last_run <= run;
            end
        end
    end

    // ====
    // Properties; the tolerance of about 1 us covers the free-running tick.
    AST_TX_WIDTH: assert property ($fell(line_drive) |->
        (hi_w > 17'h01EBE && hi_w < 17'h01FC2) || (hi_w > 17'h03E3E && hi_w < 17'h03F42)
        || (hi_w > 17'h06126 && hi_w < 17'h0622A)) else $error("drive pulse width off");
    AST_SOF_WAIT: assert property ($rose(line_drive) && !tx_is_ifr && lo_w > 17'h05014
        |-> lo_w > 17'h088B8) else $error("frame started before separation");
    AST_ARB_RELEASE: assert property (arb_lost |=> !line_drive [*8])
        else $error("line held after lost arbitration");
    AST_HS_NOTX: assert property (hs_mode |-> !$rose(line_drive))
        else $error("drive in fast receive mode");
    AST_EOD_GAP: assert property (rx_eod |-> lo_w > (hs_mode ? 17'h01388 : 17'h04F4C))
        else $error("end of data too early");
    AST_EOF_GAP: assert property (rx_eof |-> lo_w > (hs_mode ? 17'h01CE8 : 17'h07468))
        else $error("end of frame too early");
    AST_BRK: assert property (rx_brk |-> (run > 17'h01CE8 || last_run > 17'h01CE8))
        else $error("break on short pulse");
    AST_ILL: assert property (rx_illegal |-> last_run < (hs_mode ? 17'h00479 : 17'h011F8))
        else $error("illegal flag on legal run");
    AST_RX_HOLD: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("received byte not held");
    AST_RESET: assert property ($fell(srst) |-> tx_ready && !line_drive && !rx_valid)
        else $error("bad state after reset");
    cover property (arb_lost);
    cover property (rx_eof);
    cover property (rx_brk);
endmodule // vsfa_top_asserts

`default_nettype wire

// *** testbench/vsfa_node_model.sv ***
// Model of another node on the wired-OR line, sending timed symbols.
// Assumes the bench ORs drv into the line that the block sees.
`timescale 1ns/1ps
`default_nettype none

module vsfa_node_model (
    output logic drv
);
    // ====
    // The node rests passive until told to send.
    initial drv = 1'b0;

    // One symbol: a level held for us microseconds, divided by the rate sc.
    task automatic sym(input logic lvl, input int us, input int sc);
        drv = lvl;
        #(us * 1000 / sc);
    endtask

    // Start of frame, then n bits MSB first; the node then lets go.
    task automatic send(input logic [15:0] d, input int n, input int sc);
        int i;
        sym(1'b1, 200, sc);
        for (i = 0; i < n; i++) begin
            sym(i[0], (d[15 - i] ^ i[0]) ? 128 : 64, sc);
        end
        drv = 1'b0;
    endtask
endmodule // vsfa_node_model

`default_nettype wire

// *** testbench/tb_vsfa_top.sv ***
// Bench for the link block: lost arbitration, fast receive with a stalled
// reader, illegal and break pulses. Assumes the node model shares the line.
`timescale 1ns/1ps
`default_nettype none

module tb_vsfa_top;
    // ====
    // Clock, line and ports.
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic hs_mode = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic tx_last = 1'b0;
    logic tx_valid = 1'b0;
    logic tx_is_ifr = 1'b0;
    logic [1:0] ifr_type = 2'h0;
    logic rx_ready = 1'b0;
    int n_fail = 0;
    int n_compared = 0;
    int n_sof, n_eod, n_eof, n_brk, n_ill, n_arb, n_done;
    wire node_drv, line_in, line_drive, tx_ready, rx_ifr, rx_valid;
    wire rx_sof, rx_eod, rx_eof, rx_brk, rx_illegal, arb_lost, tx_done, bus_idle;
    wire [7:0] rx_data;
    assign line_in = line_drive | node_drv;
    always #4 sys_clk = ~sys_clk;

    vsfa_top u_vsfa_top (.sys_clk(sys_clk), .srst(srst), .line_in(line_in),
        .line_drive(line_drive), .hs_mode(hs_mode), .tx_data(tx_data), .tx_last(tx_last),
        .tx_is_ifr(tx_is_ifr), .ifr_type(ifr_type), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_ifr(rx_ifr), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_sof(rx_sof), .rx_eod(rx_eod), .rx_eof(rx_eof), .rx_brk(rx_brk),
        .rx_illegal(rx_illegal), .rx_nb_crc(), .rx_ovf(), .len_err(), .arb_lost(arb_lost),
        .tx_done(tx_done), .bus_idle(bus_idle));
    vsfa_node_model u_vsfa_node_model (.drv(node_drv));

    // Event pulses last one cycle, so they are counted at every edge.
    always @(posedge sys_clk) begin
        n_sof += (rx_sof === 1'b1);
        n_eod += (rx_eod === 1'b1);
        n_eof += (rx_eof === 1'b1);
        n_brk += (rx_brk === 1'b1);
        n_ill += (rx_illegal === 1'b1);
        n_arb += (arb_lost === 1'b1);
        n_done += (tx_done === 1'b1);
    end

    // ====
    // Shared tasks; inputs move 1 ns after the edge so the edge's updates land first.
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic clr;
        {n_sof, n_eod, n_eof, n_brk, n_ill, n_arb, n_done} = '0;
    endtask
    // Cycles until line_drive reaches lvl; running out ends the run.
    task automatic wait_drv(input logic lvl, input int lim, output int t);
        for (t = 0; line_drive !== lvl; t++) begin
            if (t == lim) begin
                n_fail++;
                tally_and_finish;
            end
            tick;
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ====
    // Scenarios.
    task automatic t_arb;
        int t;
        clr;
        tx_data = 8'hD5;
        tx_last = 1'b1;
        tx_valid = 1'b1;
        tick;
        tx_valid = 1'b0;
        wait_drv(1'b1, 45000, t);
        chk("sof_wait", t > 34900, 1);
        fork
            u_vsfa_node_model.send(16'h8000, 2, 1);
        join_none
        wait_drv(1'b0, 26000, t);
        chk("sof_width", t > 24870 && t < 25130, 1);
        wait_drv(1'b1, 17000, t);
        chk("long_passive", t > 15870 && t < 16130, 1);
        wait_drv(1'b0, 9000, t);
        chk("short_active", t > 7870 && t < 8130, 1);
        for (t = 0; n_arb == 0 && t < 10000; t++) begin
            tick;
        end
        chk("arb_lost", n_arb, 1);
        chk("released", line_drive, 0);
        chk("no_done", n_done, 0);
        chk("rx_sof", n_sof, 1);
        $display("t_arb done");
    endtask

    task automatic t_rx;
        int t;
        hs_mode = 1'b1;
        for (t = 0; bus_idle !== 1'b1 && t < 30000; t++) begin
            tick;
        end
        chk("idle", bus_idle, 1);
        clr;
        u_vsfa_node_model.send(16'h553C, 16, 4);
        for (t = 0; n_eof == 0 && t < 20000; t++) begin
            tick;
        end
        chk("eod", n_eod, 1);
        chk("eof", n_eof, 1);
        chk("sof_fast", n_sof, 1);
        chk("first", {rx_valid, rx_ifr, rx_data}, 10'h255);
        rx_ready = 1'b1;
        tick;
        rx_ready = 1'b0;
        tick;
        chk("second", {rx_valid, rx_data}, 9'h13C);
        rx_ready = 1'b1;
        tick;
        rx_ready = 1'b0;
        tick;
        chk("drained", rx_valid, 0);
        $display("t_rx done");
    endtask

    task automatic t_err;
        clr;
        u_vsfa_node_model.sym(1'b1, 5, 1);
        u_vsfa_node_model.sym(1'b0, 20, 1);
        chk("illegal", n_ill, 1);
        u_vsfa_node_model.sym(1'b1, 80, 1);
        u_vsfa_node_model.sym(1'b0, 100, 1);
        chk("break", n_brk, 1);
        $display("t_err done");
    endtask

    // Reset is held for five cycles, then the scenarios run in turn.
    initial begin
        clr;
        repeat (5) tick;
        srst = 1'b0;
        t_arb;
        t_rx;
        t_err;
        tally_and_finish;
    end
endmodule // tb_vsfa_top

bind vsfa_top vsfa_top_asserts u_vsfa_top_asserts (.sys_clk(sys_clk), .srst(srst),
    .line_in(line_in), .line_drive(line_drive), .hs_mode(hs_mode), .tx_ready(tx_ready),
    .tx_is_ifr(tx_is_ifr), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_eod(rx_eod), .rx_eof(rx_eof), .rx_brk(rx_brk), .rx_illegal(rx_illegal),
    .arb_lost(arb_lost));

`default_nettype wire
